// *** logic/usbsr_pkg.sv ***
package usbsr_pkg;
  // register map: the control/status byte sits at its documented address
  localparam logic [15:0] CTL_STATUS_ADDR = 16'h7FD6;
  // field positions inside the control/status byte
  localparam int WAKE_SOURCE_BIT   = 7;
  localparam int DISCONNECT_BIT    = 3;
  localparam int DISC_OE_BIT       = 2;
  localparam int PERSONALITY_BIT   = 1;
  localparam int RESUME_SIGNAL_BIT = 0;
  localparam logic [7:0] CTL_STATUS_RESET = 8'h00;
  // timing
  localparam int  CLK_HZ         = 10_000_000;
  localparam int  IDLE_SUSPEND_US = 3000;
  localparam int  IDLE_SUSPEND_CYCLES = IDLE_SUSPEND_US * (CLK_HZ / 1_000_000);
  localparam int  OSC_RESTART_CYCLES_DEF = 64;
  localparam int  CNT_W          = 16;
  // descriptor byte 7: attributes, self-powered off, remote wakeup bit 5 clear
  localparam int         DESC_ATTR_INDEX = 7;
  localparam logic [7:0] DESC_ATTR_VALUE = 8'h80;
  localparam logic [7:0] DESC_REMOTE_WAKE_MASK = 8'h20;

  typedef enum logic [1:0] {
    USBSR_RUN     = 2'b00,
    USBSR_SUSPEND = 2'b01,
    USBSR_RESTART = 2'b10
  } usbsr_state_t;

  // firmware register access bundle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } usbsr_bus_t;

  // line drive bundle toward the transceiver
  typedef struct packed {
    logic drv_en;
    logic dp;
    logic dm;
  } usbsr_line_t;
endpackage

// *** logic/usbsr_sync.sv ***
`timescale 1ns/10ps
// two-stage synchroniser for levels arriving from pins
module usbsr_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_rst_val,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  // first stage only feeds the second
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_q <= meta_d;
      o_sync <= sync_d;
    end
  end
endmodule // usbsr_sync

// *** logic/usbsr_core.sv ***
`timescale 1ns/10ps
module usbsr_core #(
  parameter int OSC_RESTART_CYCLES = usbsr_pkg::OSC_RESTART_CYCLES_DEF,
  parameter int SUSPEND_CYCLES     = usbsr_pkg::IDLE_SUSPEND_CYCLES
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_wake_n,
  input  wire logic                   i_sof,
  input  wire logic                   i_bus_active,
  input  wire logic                   i_idle_request_bit,
  input  wire logic                   i_desc_rd,
  input  wire logic [2:0]             i_desc_index,
  input  wire usbsr_pkg::usbsr_bus_t  i_bus,
  output logic [7:0]                  o_rdata,
  output logic                        o_rvalid,
  output usbsr_pkg::usbsr_line_t      o_line,
  output logic                        o_suspended,
  output logic                        o_osc_run,
  output logic                        o_resume_irq,
  output logic                        o_disconnect_ctl,
  output logic                        o_disconnect_output_en,
  output logic                        o_personality_select,
  output logic [7:0]                  o_desc_data
);
  localparam logic [usbsr_pkg::CNT_W-1:0] SUSP_LAST =
    usbsr_pkg::CNT_W'(SUSPEND_CYCLES - 1);
  localparam logic [usbsr_pkg::CNT_W-1:0] RESTART_LAST =
    usbsr_pkg::CNT_W'(OSC_RESTART_CYCLES - 1);

  logic wake_n_s;
  logic bus_act_s;

  // pins cross two flops before any logic looks at them
  usbsr_sync u_wake_sync (
    .i_clk     (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_rst_val (1'b1),
    .i_async   (i_wake_n),
    .o_sync    (wake_n_s)
  );
  usbsr_sync u_act_sync (
    .i_clk     (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_rst_val (1'b1),
    .i_async   (~i_bus_active),
    .o_sync    (bus_act_s)
  );

  function automatic logic hit(input usbsr_pkg::usbsr_bus_t b);
    hit = (b.addr == usbsr_pkg::CTL_STATUS_ADDR);
  endfunction

  usbsr_pkg::usbsr_state_t state_q, state_d;
  logic [usbsr_pkg::CNT_W-1:0] idle_cnt_q, idle_cnt_d;
  logic [usbsr_pkg::CNT_W-1:0] rst_cnt_q, rst_cnt_d;
  logic                        osc_q, osc_d;
  logic                        irq_q, irq_d;
  logic                        wake_src_q, wake_src_d;
  logic                        resume_sig_q, resume_sig_d;
  logic                        disconnect_ctl_q, disconnect_ctl_d;
  logic                        disconnect_output_en_q, disconnect_output_en_d;
  logic                        personality_select_q, personality_select_d;
  logic                        pin_wake;
  logic                        act_wake;
  logic                        src_clear;

  assign pin_wake  = ~wake_n_s;
  assign act_wake  = ~bus_act_s;
  assign src_clear = i_bus.wr && hit(i_bus) && i_bus.wdata[usbsr_pkg::WAKE_SOURCE_BIT];

  // suspend flop, idle timer and oscillator restart sequence
  always_comb begin
    state_d    = state_q;
    idle_cnt_d = idle_cnt_q;
    rst_cnt_d  = rst_cnt_q;
    osc_d      = osc_q;
    irq_d      = 1'b0;
    case (state_q)
      usbsr_pkg::USBSR_RUN: begin
        osc_d = 1'b1;
        if (i_sof || pin_wake) begin
          idle_cnt_d = '0;
        end else if (idle_cnt_q == SUSP_LAST) begin
          state_d    = usbsr_pkg::USBSR_SUSPEND;
          idle_cnt_d = '0;
        end else begin
          idle_cnt_d = idle_cnt_q + 1'b1;
        end
      end
      usbsr_pkg::USBSR_SUSPEND: begin
        if (pin_wake || act_wake) begin
          state_d   = usbsr_pkg::USBSR_RESTART;
          osc_d     = 1'b1;
          rst_cnt_d = '0;
        end else if (i_idle_request_bit) begin
          osc_d = 1'b0;
        end
      end
      usbsr_pkg::USBSR_RESTART: begin
        // the core clock is modelled as running; the count stands in for settling
        if (rst_cnt_q == RESTART_LAST) begin
          state_d = usbsr_pkg::USBSR_RUN;
          irq_d   = 1'b1;
        end else begin
          rst_cnt_d = rst_cnt_q + 1'b1;
        end
      end
      default: state_d = usbsr_pkg::USBSR_RUN;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= usbsr_pkg::USBSR_RUN;
      idle_cnt_q <= '0;
      rst_cnt_q  <= '0;
      osc_q      <= 1'b1;
      irq_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      idle_cnt_q <= idle_cnt_d;
      rst_cnt_q  <= rst_cnt_d;
      osc_q      <= osc_d;
      irq_q      <= irq_d;
    end
  end

  // control/status byte; a wake event beats a same-cycle clear
  always_comb begin
    wake_src_d   = wake_src_q;
    resume_sig_d = resume_sig_q;
    disconnect_ctl_d     = disconnect_ctl_q;
    disconnect_output_en_d     = disconnect_output_en_q;
    personality_select_d      = personality_select_q;
    if (i_bus.wr && hit(i_bus)) begin
      resume_sig_d = i_bus.wdata[usbsr_pkg::RESUME_SIGNAL_BIT];
      disconnect_ctl_d     = i_bus.wdata[usbsr_pkg::DISCONNECT_BIT];
      disconnect_output_en_d     = i_bus.wdata[usbsr_pkg::DISC_OE_BIT];
      personality_select_d      = i_bus.wdata[usbsr_pkg::PERSONALITY_BIT];
    end
    if (src_clear) begin
      wake_src_d = 1'b0;
    end
    if (state_q == usbsr_pkg::USBSR_SUSPEND && pin_wake) begin
      wake_src_d = 1'b1;
    end else if (state_q == usbsr_pkg::USBSR_SUSPEND && act_wake) begin
      wake_src_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_src_q   <= usbsr_pkg::CTL_STATUS_RESET[usbsr_pkg::WAKE_SOURCE_BIT];
      resume_sig_q <= usbsr_pkg::CTL_STATUS_RESET[usbsr_pkg::RESUME_SIGNAL_BIT];
      disconnect_ctl_q     <= usbsr_pkg::CTL_STATUS_RESET[usbsr_pkg::DISCONNECT_BIT];
      disconnect_output_en_q     <= usbsr_pkg::CTL_STATUS_RESET[usbsr_pkg::DISC_OE_BIT];
      personality_select_q      <= usbsr_pkg::CTL_STATUS_RESET[usbsr_pkg::PERSONALITY_BIT];
    end else begin
      wake_src_q   <= wake_src_d;
      resume_sig_q <= resume_sig_d;
      disconnect_ctl_q     <= disconnect_ctl_d;
      disconnect_output_en_q     <= disconnect_output_en_d;
      personality_select_q      <= personality_select_d;
    end
  end

  // registered outputs: read port, line drive, status and descriptor byte
  logic [7:0]             rdata_d;
  logic                   rvalid_d;
  usbsr_pkg::usbsr_line_t line_d;
  logic [7:0]             desc_d;
  logic                   susp_now;

  assign susp_now = (state_d == usbsr_pkg::USBSR_SUSPEND);

  always_comb begin
    rdata_d  = 8'h00;
    rvalid_d = i_bus.rd;
    if (i_bus.rd && hit(i_bus)) begin
      rdata_d[usbsr_pkg::WAKE_SOURCE_BIT]   = wake_src_q;
      rdata_d[usbsr_pkg::DISCONNECT_BIT]    = disconnect_ctl_q;
      rdata_d[usbsr_pkg::DISC_OE_BIT]       = disconnect_output_en_q;
      rdata_d[usbsr_pkg::PERSONALITY_BIT]   = personality_select_q;
      rdata_d[usbsr_pkg::RESUME_SIGNAL_BIT] = resume_sig_q;
    end
    // K means D- high, D+ low; released line shows J through the resistors
    line_d.drv_en = resume_sig_d && !susp_now;
    line_d.dp     = 1'b0;
    line_d.dm     = resume_sig_d && !susp_now;
    desc_d = 8'h00;
    if (i_desc_rd && i_desc_index == 3'(usbsr_pkg::DESC_ATTR_INDEX)) begin
      desc_d = usbsr_pkg::DESC_ATTR_VALUE & ~usbsr_pkg::DESC_REMOTE_WAKE_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata     <= 8'h00;
      o_rvalid    <= 1'b0;
      o_line      <= '0;
      o_suspended <= 1'b0;
      o_desc_data <= 8'h00;
    end else begin
      o_rdata     <= rdata_d;
      o_rvalid    <= rvalid_d;
      o_line      <= line_d;
      o_suspended <= susp_now;
      o_desc_data <= desc_d;
    end
  end

  assign o_osc_run              = osc_q;
  assign o_resume_irq           = irq_q;
  assign o_disconnect_ctl       = disconnect_ctl_q;
  assign o_disconnect_output_en = disconnect_output_en_q;
  assign o_personality_select   = personality_select_q;
endmodule // usbsr_core

// *** testbench/usbsr_properties.sv ***
`timescale 1ns/10ps
// port-level checks of suspend entry, wakeup and resume signalling
module usbsr_properties #(
  parameter int SUSPEND_CYCLES     = 50,
  parameter int OSC_RESTART_CYCLES = 4
) (
  input wire logic                   i_mclk,
  input wire logic                   i_rst_n,
  input wire logic                   i_wake_n,
  input wire logic                   i_sof,
  input wire logic                   i_idle_request_bit,
  input wire logic                   i_desc_rd,
  input wire logic [2:0]             i_desc_index,
  input wire usbsr_pkg::usbsr_bus_t  i_bus,
  input wire usbsr_pkg::usbsr_line_t o_line,
  input wire logic                   o_suspended,
  input wire logic                   o_osc_run,
  input wire logic                   o_resume_irq,
  input wire logic [7:0]             o_desc_data
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] idle_q;
  logic [15:0] idle_d;
  wire logic   ctl_wr = i_bus.wr && i_bus.addr == usbsr_pkg::CTL_STATUS_ADDR;
  // cycles since the last frame marker; saturates so a long sleep never wraps
  always_comb begin
    idle_d = i_sof ? 16'h0000 : idle_q + {15'h0000, ~&idle_q};
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) idle_q <= 16'h0000;
    else idle_q <= idle_d;
  end
  // restart: quiet for a few cycles, then the resume pulse
  sequence s_restart;
    !o_resume_irq [*3] ##[1:8] o_resume_irq;
  endsequence
  sequence s_wake_low;
    !i_wake_n [*4];
  endsequence
  a_idle_before_suspend: assert property (
    $rose(o_suspended) |-> idle_q >= SUSPEND_CYCLES - 1) else $error("suspend too early");
  a_suspend_drv_off: assert property (
    o_suspended |-> !o_line.drv_en) else $error("driver on while suspended");
  a_wake_pin_hold: assert property (
    s_wake_low |-> !o_suspended) else $error("suspended with wake pin low");
  a_k_state_level: assert property (
    o_line.drv_en |-> o_line.dm && !o_line.dp) else $error("driven state is not K");
  a_resume_bit_drive: assert property (
    ctl_wr && !o_suspended |-> ##2 o_line.drv_en == $past(i_bus.wdata[0], 2))
    else $error("line drive does not follow resume bit");
  a_irq_after_restart: assert property (
    $fell(o_suspended) |-> s_restart) else $error("resume pulse timing wrong");
  a_osc_idle_stop: assert property (
    (o_suspended && i_idle_request_bit) [*2] |-> ##[0:2] !o_osc_run)
    else $error("oscillator not stopped");
  a_desc_no_wake: assert property (
    i_desc_rd && i_desc_index == 3'h7 |=> o_desc_data == usbsr_pkg::DESC_ATTR_VALUE &&
    (o_desc_data & usbsr_pkg::DESC_REMOTE_WAKE_MASK) == 8'h00)
    else $error("descriptor claims remote wakeup");
endmodule // usbsr_properties

bind usbsr_core usbsr_properties #(.SUSPEND_CYCLES(SUSPEND_CYCLES),
  .OSC_RESTART_CYCLES(OSC_RESTART_CYCLES)) u_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_wake_n(i_wake_n), .i_sof(i_sof), .i_idle_request_bit(i_idle_request_bit),
  .i_desc_rd(i_desc_rd), .i_desc_index(i_desc_index), .i_bus(i_bus), .o_line(o_line),
  .o_suspended(o_suspended), .o_osc_run(o_osc_run), .o_resume_irq(o_resume_irq),
  .o_desc_data(o_desc_data));

// *** testbench/usbsr_host_model.sv ***
`timescale 1ns/10ps
// upstream port: frame markers while live, resume activity on demand
module usbsr_host_model #(
  parameter int SOF_GAP = 20
) (
  input  wire logic i_mclk,
  input  wire logic i_frames_on,
  input  wire logic i_resume,
  output logic      o_sof = 1'b0,
  output logic      o_bus_active = 1'b0
);
  int cnt = 0;
  // silence on the markers is what lets the device fall asleep
  always @(posedge i_mclk) begin
    cnt <= (cnt + 1) % SOF_GAP;
    o_sof <= i_frames_on && cnt == 0;
    o_bus_active <= i_resume;
  end
endmodule // usbsr_host_model

// *** testbench/usb_suspend_remote_wakeup_tb_top.sv ***
`timescale 1ns/10ps
module usb_suspend_remote_wakeup_tb_top;
  localparam logic [15:0] CA = usbsr_pkg::CTL_STATUS_ADDR;
  localparam int          SC = 50;
  logic                   i_mclk = 1'b0;
  logic                   i_rst_n = 1'b0;
  logic                   i_wake_n = 1'b1;
  logic                   i_idle_request_bit = 1'b0;
  logic                   i_desc_rd = 1'b0;
  logic [2:0]             i_desc_index = 3'h0;
  usbsr_pkg::usbsr_bus_t  i_bus = '0;
  logic                   frames_on = 1'b1;
  logic                   resume = 1'b0;
  logic                   sof, bus_act, o_rvalid, o_suspended, o_osc_run, o_resume_irq;
  logic                   o_disc, o_disc_oe, o_pers;
  logic [7:0]             o_rdata, o_desc_data, d;
  usbsr_pkg::usbsr_line_t o_line;
  logic [7:0]             exp_q[$];
  logic [31:0]            seed = 32'hF9AB9A56;
  logic [31:0]            r;
  int                     miscompares = 0;
  int                     compares = 0;
  int                     cyc = 0;
  int                     n;
  always #50 i_mclk = ~i_mclk;
  usbsr_host_model u_host (.i_mclk(i_mclk), .i_frames_on(frames_on), .i_resume(resume),
    .o_sof(sof), .o_bus_active(bus_act));
  usbsr_core #(.OSC_RESTART_CYCLES(4), .SUSPEND_CYCLES(SC)) DUT (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wake_n(i_wake_n), .i_sof(sof),
    .i_bus_active(bus_act), .i_idle_request_bit(i_idle_request_bit), .i_desc_rd(i_desc_rd),
    .i_desc_index(i_desc_index), .i_bus(i_bus), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_line(o_line), .o_suspended(o_suspended), .o_osc_run(o_osc_run),
    .o_resume_irq(o_resume_irq), .o_disconnect_ctl(o_disc),
    .o_disconnect_output_en(o_disc_oe), .o_personality_select(o_pers),
    .o_desc_data(o_desc_data));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus cycle; the idle edge after it keeps strobes from merging
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_bus <= {w, ~w, a, v};
    @(posedge i_mclk);
    i_bus <= '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  // k: 0 suspend seen, 1 resume pulse seen; bounded so a hang still ends
  task automatic wait_on(input int k, output int t);
    for (t = 1; t < 300; t++) begin
      @(negedge i_mclk);
      if ((k == 0 ? o_suspended : o_resume_irq) === 1'b1) break;
    end
  endtask
  task automatic sleep();
    do @(negedge i_mclk); while (sof !== 1'b1);
    @(posedge i_mclk);
    frames_on <= 1'b0;
    wait_on(0, n);
    chk("idle_time", 8'h01, n >= SC && n <= SC + 6);
  endtask
  task automatic wake(input logic pin);
    @(posedge i_mclk);
    i_wake_n <= !pin;
    resume <= !pin;
    repeat (4) @(posedge i_mclk);
    i_wake_n <= 1'b1;
    resume <= 1'b0;
    frames_on <= 1'b1;
    wait_on(1, n);
    chk("irq_seen", 8'h01, n < 20);
    chk("osc_run", 8'h01, o_osc_run);
  endtask
  // read results are matched against the oldest noted expectation
  always @(negedge i_mclk) begin
    if (o_rvalid === 1'b1) chk("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, o_rdata);
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(CA, usbsr_pkg::CTL_STATUS_RESET);
    r = rnd();
    acc(1'b1, {r[15:1], 1'b1}, 8'hFF);
    rd({r[15:1], 1'b1}, 8'h00);
    d = r[23:16] & 8'h0E;
    acc(1'b1, CA, d);
    rd(CA, d);
    chk("ctl_bits", d[3:1], {o_disc, o_disc_oe, o_pers});
    acc(1'b1, CA, 8'h01);
    repeat (2) @(negedge i_mclk);
    chk("k_line", 8'h05, o_line);
    acc(1'b1, CA, 8'h00);
    repeat (2) @(negedge i_mclk);
    chk("released", 8'h00, o_line.drv_en);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_mclk);
      i_desc_rd <= 1'b1;
      i_desc_index <= i[2:0];
      @(posedge i_mclk);
      i_desc_rd <= 1'b0;
      @(negedge i_mclk);
      chk("desc", i == 7 ? usbsr_pkg::DESC_ATTR_VALUE : 8'h00, o_desc_data);
    end
    @(posedge i_mclk);
    i_wake_n <= 1'b0;
    frames_on <= 1'b0;
    repeat (SC + 20) @(negedge i_mclk);
    chk("held_awake", 8'h00, o_suspended);
    @(posedge i_mclk);
    i_wake_n <= 1'b1;
    // frames must run again, or the next sleep never sees a marker to start from
    frames_on <= 1'b1;
    sleep();
    wake(1'b1);
    rd(CA, 8'h80);
    acc(1'b1, CA, 8'h00);
    rd(CA, 8'h80);
    sleep();
    wake(1'b0);
    rd(CA, 8'h00);
    sleep();
    // host is taken to have enabled remote wakeup before this resume request
    acc(1'b1, CA, 8'h01);
    @(posedge i_mclk);
    i_idle_request_bit <= 1'b1;
    repeat (4) @(negedge i_mclk);
    chk("drv_off", 8'h00, o_line.drv_en);
    chk("osc_stop", 8'h00, o_osc_run);
    @(posedge i_mclk);
    i_idle_request_bit <= 1'b0;
    wake(1'b1);
    @(negedge i_mclk);
    chk("k_after_wake", 8'h05, o_line);
    repeat (10) @(posedge i_mclk);
    acc(1'b1, CA, 8'h00);
    acc(1'b1, CA, 8'h80);
    rd(CA, 8'h00);
    repeat (3) @(negedge i_mclk);
    report_and_stop();
  end
endmodule // usb_suspend_remote_wakeup_tb_top
